/* rtl/pbsc_defines.vh */
`ifndef PBSC_DEFINES_VH
`define PBSC_DEFINES_VH
// config dword offsets (byte addresses)
`define PBSC_MASK_OFFSET 8'h64
`define PBSC_CLK_STAT_OFFSET 8'h68
// mask register byte 0 at 0x64
`define PBSC_MASK_RESET 8'h00
`define PBSC_MASK_WMASK 8'h7E
// clock control in bytes 1:0 of 0x68
`define PBSC_CLK_RESET 16'h3E00
`define PBSC_CLK_WMASK 16'h01FF
`define PBSC_CLK_RO_ONES 16'h3E00
// status byte 2 of 0x68
`define PBSC_STAT_RESET 8'h00
// mask bit positions
`define PBSC_MB_PAR 1
`define PBSC_MB_PND 2
`define PBSC_MB_PTA 3
`define PBSC_MB_PMA 4
`define PBSC_MB_DWF 5
`define PBSC_MB_DRF 6
// status bit positions within the byte (bit 16 + n)
`define PBSC_SB_ADDR 0
`define PBSC_SB_PAR 1
`define PBSC_SB_PND 2
`define PBSC_SB_PTA 3
`define PBSC_SB_PMA 4
`define PBSC_SB_DWF 5
`define PBSC_SB_DRF 6
`define PBSC_SB_TMO 7
`endif

/* rtl/pbsc_syserr_clk_ctl.v */
`timescale 1ns/100ps
`default_nettype none
`include "pbsc_defines.vh"

// Behaviour
// - mask bit 2 clear and error enable set: posted non-delivery raises system error
// - reserved bits ignore writes and read zero, except clock control bits 13:9, which read one
// - clock out 0 field bits 1:0; value 11 stops it high
// - clock out 1 field bits 3:2; value 11 stops it high
// - clock out 2 field bits 5:4; value 11 stops it high
// - status bit 16 records address parity system error; write one clears
// - status bit 17 records posted data parity system error; write one clears
// - status bit 18 records posted non-delivery system error; write one clears
// - status bit 19 records posted target abort system error; write one clears
// - status bit 20 records posted master abort system error; write one clears
// - status bit 21 records delayed write failure system error; write one clears
// - status bit 22 records delayed read failure system error; write one clears
// - status bit 23 records master retry time-out system error
// - mask bits 6..3 gate delayed read, delayed write, master and target abort
module pbsc_syserr_clk_ctl (
   input wire ref_clk_i,            // primary bus clock
   input wire rst_i,                // async reset, active high
   input wire cfg_wr_i,             // config write strobe
   input wire cfg_rd_i,             // config read strobe
   input wire [7:0] cfg_addr_i,     // dword-aligned config offset
   input wire [3:0] cfg_be_i,       // byte enables, active high
   input wire [31:0] cfg_wdata_i,   // write data
   output reg [31:0] cfg_rdata_o,   // read data, registered
   input wire serr_enable_i,        // command register error enable
   input wire ev_addr_parity_i,     // address parity error pulse
   input wire ev_posted_parity_i,   // posted data parity pulse
   input wire ev_posted_nodeliv_i,  // posted non-delivery pulse
   input wire ev_posted_tabort_i,   // posted target abort pulse
   input wire ev_posted_mabort_i,   // posted master abort pulse
   input wire ev_delayed_wfail_i,   // delayed write failure pulse
   input wire ev_delayed_rfail_i,   // delayed read failure pulse
   input wire ev_retry_timeout_i,   // master retry time-out pulse
   input wire [4:0] sec_clk_i,      // free-running secondary clocks
   output wire [4:0] sec_clk_o,     // gated secondary clock outputs
   output reg primary_system_error_n_o // system error, active low, one cycle
);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // an event reaches the error line only when reporting is on and not masked
   function ev_gate;
      input en;
      input ev;
      input blocked;
      begin
         ev_gate = en & ev & ~blocked;
      end
   endfunction

   // write-one-to-clear; a set in the same cycle takes priority
   function [7:0] w1c_next;
      input [7:0] cur;
      input [7:0] clr;
      input [7:0] set;
      begin
         w1c_next = (cur & ~clr) | set;
      end
   endfunction

   // write strobe for one byte lane of one decoded dword
   function lane_wr;
      input wr;
      input hit;
      input be;
      begin
         lane_wr = wr & hit & be;
      end
   endfunction

   // ---------------------------------------------------------------
   // state and decode
   // ---------------------------------------------------------------
   reg [7:0] mask_q;
   reg [7:0] mask_d;
   reg [15:0] clk_q;
   reg [15:0] clk_d;
   reg [7:0] stat_q;
   reg [7:0] stat_d;
   reg [31:0] rdata_d;
   wire [15:0] clk_ro_ones;
   wire [7:0] raw_ev;
   wire [7:0] fire;
   wire [4:0] clk_stop;
   wire hit_mask;
   wire hit_cs;
   wire wr_mask;
   wire wr_clk_lo;
   wire wr_clk_hi;
   wire wr_stat;

   assign clk_ro_ones = `PBSC_CLK_RO_ONES;
   assign hit_mask = (cfg_addr_i == `PBSC_MASK_OFFSET);
   assign hit_cs = (cfg_addr_i == `PBSC_CLK_STAT_OFFSET);
   assign wr_mask = lane_wr(cfg_wr_i, hit_mask, cfg_be_i[0]);
   assign wr_clk_lo = lane_wr(cfg_wr_i, hit_cs, cfg_be_i[0]);
   assign wr_clk_hi = lane_wr(cfg_wr_i, hit_cs, cfg_be_i[1]);
   assign wr_stat = lane_wr(cfg_wr_i, hit_cs, cfg_be_i[2]);

   // events in status bit order
   assign raw_ev = {ev_retry_timeout_i, ev_delayed_rfail_i, ev_delayed_wfail_i,
                    ev_posted_mabort_i, ev_posted_tabort_i, ev_posted_nodeliv_i,
                    ev_posted_parity_i, ev_addr_parity_i};

   // ---------------------------------------------------------------
   // event gating
   // ---------------------------------------------------------------
   // address parity and retry time-out have no mask bit
   assign fire[`PBSC_SB_ADDR] = ev_gate(serr_enable_i, raw_ev[`PBSC_SB_ADDR],
                                        1'b0);
   assign fire[`PBSC_SB_PAR] = ev_gate(serr_enable_i, raw_ev[`PBSC_SB_PAR],
                                       mask_q[`PBSC_MB_PAR]);
   assign fire[`PBSC_SB_PND] = ev_gate(serr_enable_i, raw_ev[`PBSC_SB_PND],
                                       mask_q[`PBSC_MB_PND]);
   assign fire[`PBSC_SB_PTA] = ev_gate(serr_enable_i, raw_ev[`PBSC_SB_PTA],
                                       mask_q[`PBSC_MB_PTA]);
   assign fire[`PBSC_SB_PMA] = ev_gate(serr_enable_i, raw_ev[`PBSC_SB_PMA],
                                       mask_q[`PBSC_MB_PMA]);
   assign fire[`PBSC_SB_DWF] = ev_gate(serr_enable_i, raw_ev[`PBSC_SB_DWF],
                                       mask_q[`PBSC_MB_DWF]);
   assign fire[`PBSC_SB_DRF] = ev_gate(serr_enable_i, raw_ev[`PBSC_SB_DRF],
                                       mask_q[`PBSC_MB_DRF]);
   assign fire[`PBSC_SB_TMO] = ev_gate(serr_enable_i, raw_ev[`PBSC_SB_TMO],
                                       1'b0);

   // ---------------------------------------------------------------
   // next-state logic
   // ---------------------------------------------------------------
   always @* begin
      mask_d = mask_q;
      if (wr_mask) begin
         mask_d = cfg_wdata_i[7:0] & `PBSC_MASK_WMASK;
      end
   end

   always @* begin
      clk_d = clk_q;
      if (wr_clk_lo) begin
         clk_d[7:0] = cfg_wdata_i[7:0];
      end
      if (wr_clk_hi) begin
         // only bit 8 is writable; 13:9 stay one and 15:14 stay zero
         clk_d[15:8] = clk_ro_ones[15:8] | {7'h00, cfg_wdata_i[8]};
      end
   end

   always @* begin
      if (wr_stat) begin
         stat_d = w1c_next(stat_q, cfg_wdata_i[23:16], fire);
      end else begin
         stat_d = w1c_next(stat_q, 8'h00, fire);
      end
   end

   always @* begin
      rdata_d = 32'h00000000;
      if (hit_mask) begin
         rdata_d = {24'h000000, mask_q};
      end else if (hit_cs) begin
         rdata_d = {8'h00, stat_q, clk_q};
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         mask_q <= `PBSC_MASK_RESET;
         clk_q <= `PBSC_CLK_RESET;
         stat_q <= `PBSC_STAT_RESET;
      end else begin
         mask_q <= mask_d;
         clk_q <= clk_d;
         stat_q <= stat_d;
      end
   end

   // error line is low for one cycle per cycle with any unmasked event
   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         primary_system_error_n_o <= 1'b1;
      end else begin
         primary_system_error_n_o <= ~(|fire);
      end
   end

   // read data holds until the next read; unmapped offsets read zero
   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cfg_rdata_o <= 32'h00000000;
      end else if (cfg_rd_i) begin
         cfg_rdata_o <= rdata_d;
      end
   end

   // ---------------------------------------------------------------
   // clock gating: stopped outputs are held high
   // ---------------------------------------------------------------
   // a stop only forces the output high, so a stop never cuts a high phase short
   assign clk_stop[0] = &clk_q[1:0];
   assign clk_stop[1] = &clk_q[3:2];
   assign clk_stop[2] = &clk_q[5:4];
   assign clk_stop[3] = &clk_q[7:6];
   assign clk_stop[4] = clk_q[8];

   assign sec_clk_o = sec_clk_i | clk_stop;

endmodule
`default_nettype wire

/* verification/pbsc_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module pbsc_properties (
   input wire logic ref_clk_i, rst_i, cfg_rd_i, serr_enable_i, primary_system_error_n_o,
   input wire logic ev_addr_parity_i, ev_retry_timeout_i,
   input wire logic [7:0] cfg_addr_i,
   input wire logic [31:0] cfg_rdata_o,
   input wire logic [4:0] sec_clk_i, sec_clk_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   logic rd64, rd68;
   assign rd64 = cfg_rd_i && cfg_addr_i == 8'h64;
   assign rd68 = cfg_rd_i && cfg_addr_i == 8'h68;
   property p_top; rd68 |=> cfg_rdata_o[31:24] == 8'h00; endproperty
   a_top: assert property (p_top) else $error("top byte");
   property p_ro; rd68 |=> cfg_rdata_o[15:9] == 7'h1F; endproperty
   a_ro: assert property (p_ro) else $error("fixed clock bits");
   property p_msk; rd64 |=> cfg_rdata_o[31:7] == 25'h0 && !cfg_rdata_o[0]; endproperty
   a_msk: assert property (p_msk) else $error("mask spare bits");
   property p_unm; cfg_rd_i && !rd64 && !rd68 |=> cfg_rdata_o == 32'h0; endproperty
   a_unm: assert property (p_unm) else $error("unmapped read");
   property p_off; !serr_enable_i |=> primary_system_error_n_o; endproperty
   a_off: assert property (p_off) else $error("error while disabled");
   property p_adr; ev_addr_parity_i && serr_enable_i |=> !primary_system_error_n_o; endproperty
   a_adr: assert property (p_adr) else $error("address parity");
   property p_tmo; ev_retry_timeout_i && serr_enable_i |=> !primary_system_error_n_o; endproperty
   a_tmo: assert property (p_tmo) else $error("retry timeout");
   property p_gate; (sec_clk_i & ~sec_clk_o) == 5'h00; endproperty
   a_gate: assert property (p_gate) else $error("clock stopped low");
endmodule
bind pbsc_syserr_clk_ctl pbsc_properties pbsc_properties_i (.*);
`default_nettype wire

/* verification/pbsc_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module pbsc_host_model (
   input wire logic ref_clk_i, // bus clock
   input wire logic [7:0] req_i, // events to raise
   output logic [7:0] ev_o, // event pulses
   output logic [4:0] sck_o // raw secondary clocks
);
   initial sck_o = 5'h00;
   always @(posedge ref_clk_i) begin
      ev_o <= req_i;
      sck_o <= ~sck_o;
   end
endmodule
`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic ref_clk_i = 1'b0, rst_i = 1'b1, cfg_wr_i = 1'b0, cfg_rd_i = 1'b0, en = 1'b1;
   logic [7:0] cfg_addr_i = 8'h00, req = 8'h00;
   logic [3:0] cfg_be_i = 4'h0;
   logic [31:0] cfg_wdata_i = 32'h0;
   wire [31:0] rdata;
   wire [7:0] ev;
   wire [4:0] sck, sclk;
   wire serr_n;
   int num_errors = 0, comparisons = 0, cyc = 0;
   always #2 ref_clk_i = ~ref_clk_i;
   pbsc_host_model pbsc_host_model_i (.ref_clk_i(ref_clk_i), .req_i(req), .ev_o(ev), .sck_o(sck));
   pbsc_syserr_clk_ctl pbsc_syserr_clk_ctl_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i), .cfg_be_i(cfg_be_i),
      .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(rdata), .serr_enable_i(en),
      .ev_addr_parity_i(ev[0]), .ev_posted_parity_i(ev[1]), .ev_posted_nodeliv_i(ev[2]),
      .ev_posted_tabort_i(ev[3]), .ev_posted_mabort_i(ev[4]), .ev_delayed_wfail_i(ev[5]),
      .ev_delayed_rfail_i(ev[6]), .ev_retry_timeout_i(ev[7]), .sec_clk_i(sck),
      .sec_clk_o(sclk), .primary_system_error_n_o(serr_n));
   task chk(input [31:0] g, input [31:0] e);
      comparisons++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task wr(input [7:0] a, input [3:0] b, input [31:0] d);
      @(posedge ref_clk_i) {cfg_wr_i, cfg_addr_i, cfg_be_i, cfg_wdata_i} <= {1'b1, a, b, d};
      @(posedge ref_clk_i) cfg_wr_i <= 1'b0;
   endtask
   task rd(input [7:0] a, input [31:0] e);
      @(posedge ref_clk_i) {cfg_rd_i, cfg_addr_i} <= {1'b1, a};
      @(posedge ref_clk_i) cfg_rd_i <= 1'b0;
      @(negedge ref_clk_i) chk(rdata, e);
   endtask
   task fire(input [7:0] v, input [31:0] e);
      @(posedge ref_clk_i) req <= v;
      @(posedge ref_clk_i) req <= 8'h00;
      @(posedge ref_clk_i);
      @(negedge ref_clk_i) chk(serr_n, e);
   endtask
   task t_clocks;
      logic [1:0] v;
      for (int i = 0; i < 4; i++) begin
         v = i[1:0];
         wr(8'h68, 4'h3, {16'h0, 7'h7F, v[0], v, v, v, v});
         rd(8'h68, {16'h0, 7'h1F, v[0], v, v, v, v});
         @(negedge ref_clk_i) chk(sclk, sck | {v[0], {4{&v}}});
      end
      wr(8'h68, 4'h3, 32'h0);
      $display("t_clocks done");
   endtask
   task t_events;
      for (int i = 0; i < 8; i++) begin
         fire(8'h01 << i, 0);
         rd(8'h68, {8'h00, 8'h01 << i, 16'h3E00});
         wr(8'h68, 4'h4, 32'h00FF0000);
         rd(8'h68, 32'h3E00);
      end
      $display("t_events done");
   endtask
   task t_mask;
      wr(8'h64, 4'h1, 32'hFF);
      rd(8'h64, 32'h7E);
      for (int i = 1; i < 7; i++) fire(8'h01 << i, 1);
      wr(8'h64, 4'h1, 32'h0);
      en <= 1'b0;
      fire(8'h06, 1);
      rd(8'h68, 32'h3E00);
      en <= 1'b1;
      rd(8'h60, 32'h0);
      $display("t_mask done");
   endtask
   task test_done;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         test_done;
      end
   end
   initial begin
      repeat (5) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      rd(8'h64, 32'h0);
      rd(8'h68, 32'h3E00);
      t_clocks;
      t_events;
      t_mask;
      test_done;
   end
endmodule
`default_nettype wire
